// ===== pkg/nubus_seq_pkg.sv
// constants, types and decode helpers for the host bus sequencer
package nubus_seq_pkg;

   // system clock and host bus clock
   localparam int CLK_PERIOD_NS    = 10;
   localparam int NB_PERIOD_NS     = 100;          // 10 MHz host bus clock

   // host bus timeout and the guard kept well inside it
   localparam int NB_TIMEOUT_NS    = 25600;
   localparam int ACK_GUARD_NS     = NB_TIMEOUT_NS / 2;
   localparam int ACK_GUARD_CLKS   = ACK_GUARD_NS / NB_PERIOD_NS;
   localparam int WAIT_W           = 8;
   localparam logic [WAIT_W-1:0] WAIT_LIMIT = WAIT_W'(ACK_GUARD_CLKS - 1);
   localparam logic [WAIT_W-1:0] WAIT_ZERO  = 8'h00;

   // longest local bus occupation by one RAM host access
   localparam int LOCAL_HOLD_NS    = 500;
   localparam int LOCAL_HOLD_CLKS  = LOCAL_HOLD_NS / NB_PERIOD_NS;

   // address field layout
   localparam int AD_W             = 32;
   localparam int SLOT_HI          = 31;
   localparam int SLOT_LO          = 24;
   localparam int DEV_HI           = 19;
   localparam int DEV_LO           = 18;
   localparam int WORD_HI          = 15;
   localparam int RAM_WORD_HI      = 14;
   localparam int WORD_LO          = 2;
   localparam int LOCAL_W          = WORD_HI - WORD_LO + 1;
   localparam int REG_SEL_W        = 4;
   localparam logic [3:0] SLOT_SPACE = 4'hF;

   // device select codes on the two device bits
   localparam logic [1:0] DEV_CODE_CTRL = 2'h0;
   localparam logic [1:0] DEV_CODE_ROM  = 2'h1;
   localparam logic [1:0] DEV_CODE_RAM  = 2'h2;

   // transfer mode: bit 1 low on the wire asks for a write
   localparam int TM_WRITE_BIT     = 1;

   // status levels driven on the transfer mode wires
   localparam logic [1:0] TM_COMPLETE  = 2'h3;
   localparam logic [1:0] TM_BUS_ERROR = 2'h2;

   // synchroniser bundle width
   localparam int SYNC_W           = 1 + 1 + 2 + 4 + AD_W + 1 + 1;

   typedef enum logic [2:0] {S0, S1, S2, S3, S4, S5, S6} seq_state_t;
   typedef enum logic [1:0] {DEV_CTRL, DEV_ROM, DEV_RAM, DEV_NONE} dev_t;

   // device selected by a latched address
   function automatic dev_t dev_of(input logic [AD_W-1:0] addr);
      unique case (addr[DEV_HI:DEV_LO])
         DEV_CODE_CTRL: dev_of = DEV_CTRL;
         DEV_CODE_ROM:  dev_of = DEV_ROM;
         DEV_CODE_RAM:  dev_of = DEV_RAM;
         default:       dev_of = DEV_NONE;
      endcase
   endfunction

   // write request from wire levels of the transfer mode lines
   function automatic logic is_write(input logic [1:0] tm);
      is_write = ~tm[TM_WRITE_BIT];
   endfunction

endpackage

// ===== design/sync_two_ff.sv
// two flip-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ns
module sync_two_ff #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // asynchronous in, synchronised out
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;

endmodule

// ===== design/nubus_sequencer.sv
// host bus slave sequencer and local bus arbiter for the network card
//
// Notes on behaviour
// - synchronous machine on the host bus clock; S0 idle, S1-S5 host, S6 controller
// - requests accepted only in S0; running cycles finish back in S0 first
// - controller request beats a host request when both wait in S0
// - buffer RAM access walks S0, S1, S2, S3, S4, S0
// - bus error when no device is selected or ROM is written
// - bus error goes S1 to S5; S5 drops strobe, acknowledges with error, idles
// - address latch open while idle unless a foreign-slot start shut it, captures and shuts at the falling clock edge that sees start
// - host address drives local bus unless controller owns or requests it idle
// - upper eight address bits compared with backplane slot identity
// - start sets cycle valid; S0 to S1 needs it, slot match, no request
// - data strobe qualifier in S1, S3, S4 gates every chip select and enable outside S2
// - in S2 the strobe drops; upper qualifier gates RAM and buffer enables
// - ROM read enables ROM and outbound buffer, then S4 acknowledge complete
// - register access asserts controller select; local address carries address bits 15-2
// - register access waits in S1 for synchronised controller acknowledge
// - register write drives write data and strobe, strobe drops at S4 fall
// - register read enables the outbound data buffer
// - every host access acknowledged well within the host bus timeout
// - no RAM or ROM access holds the local bus beyond five host clocks; register access up to the wait limit
// - only two status codes: complete both high, error line 0 low
// - address bits 19-18 select device; 23-20 and 1-0 ignored
// - RAM word split in two halves, low local bit clear then set
// - idle with controller request enters S6, stays until request drops
`timescale 1ns/1ns
module nubus_sequencer
   import nubus_seq_pkg::*;
(
   // system clock and reset
   input  wire logic               CLK_I,
   input  wire logic               RST_I,
   // host bus pins, all asynchronous to CLK_I
   input  wire logic               NB_CLK_I,
   input  wire logic               NB_START_N_I,
   input  wire logic [AD_W-1:0]    NB_AD_I,
   input  wire logic [1:0]         NB_TM_I,
   input  wire logic [3:0]         SLOT_ID_I,
   // host bus open-drain answer
   output logic                    ACK_N_O,
   output logic                    ACK_OE_N_O,
   output logic [1:0]              TM_O,
   output logic                    TM_OE_N_O,
   // controller handshake, asynchronous to CLK_I
   input  wire logic               CTRL_BUS_REQUEST_I,
   input  wire logic               CTRL_ACCESS_ACK_N_I,
   output logic                    BUS_GRANT_O,
   output logic                    CTRL_ADDR_OUT_EN_O,
   // local bus address side
   output logic                    HOST_ADDR_LATCH_CLK_O,
   output logic                    HOST_ADDR_OUT_EN_O,
   output logic [LOCAL_W-1:0]      LOCAL_ADDR_O,
   output logic                    SLOT_MATCH_O,
   // local bus selects and data enables
   output logic                    DATA_STROBE_QUAL_O,
   output logic                    UPPER_QUAL_O,
   output logic                    CTRL_CHIP_SEL_O,
   output logic                    ROM_CHIP_SEL_O,
   output logic                    BUF_RAM_OUT_EN_O,
   output logic                    HOST_TO_LOCAL_DATA_EN_O,
   output logic                    HOST_TO_LOCAL_UPPER_EN_O,
   output logic                    LOCAL_TO_HOST_DATA_EN_O,
   // write strobes
   output logic                    CTRL_WRITE_STROBE_O,
   output logic                    RAM_WRITE_UPPER_O,
   output logic                    RAM_WRITE_LOWER_O
);

   // synchronised pins
   logic [SYNC_W-1:0] sync_q;
   logic              nb_clk_s;
   logic              start_n_s;
   logic [1:0]        tm_s;
   logic [3:0]        slot_s;
   logic [AD_W-1:0]   ad_s;
   logic              ctrl_bus_request_s;
   logic              cack_n_s;

   sync_two_ff #(.W(SYNC_W)) u_sync (
      .clk_i (CLK_I),
      .rst_i (RST_I),
      .d_i   ({NB_CLK_I, NB_START_N_I, NB_TM_I, SLOT_ID_I, NB_AD_I,
               CTRL_BUS_REQUEST_I, CTRL_ACCESS_ACK_N_I}),
      .q_o   (sync_q)
   );

   assign {nb_clk_s, start_n_s, tm_s, slot_s, ad_s, ctrl_bus_request_s, cack_n_s} = sync_q;

   // host clock edges become one-cycle enables
   logic nb_prev_reg;
   logic nb_rise;
   logic nb_fall;

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         nb_prev_reg <= 1'b0;
      end else begin
         nb_prev_reg <= nb_clk_s;
      end
   end

   assign nb_rise = nb_clk_s & ~nb_prev_reg;
   assign nb_fall = ~nb_clk_s & nb_prev_reg;

   // sequencer state group
   seq_state_t        state_reg,   state_next;
   logic [AD_W-1:0]   addr_reg,    addr_next;
   logic [1:0]        tm_reg,      tm_next;
   logic              open_reg,    open_next;
   logic              cve_reg,     cve_next;
   logic              fell_reg,    fell_next;
   logic [WAIT_W-1:0] wait_reg,    wait_next;
   logic              ack_seen;
   logic              match;
   dev_t              dev;
   logic              wr;
   logic              berr;

   assign match    = (addr_reg[SLOT_HI:SLOT_LO] == {SLOT_SPACE, slot_s});
   assign dev      = dev_of(addr_reg);
   assign wr       = is_write(tm_reg);
   assign berr     = (dev == DEV_NONE) | ((dev == DEV_ROM) & wr);
   assign ack_seen = (state_reg == S4) | (state_reg == S5);

   // next state, latch and cycle valid; all moves except an open latch following the pins happen on host clock edges
   always_comb begin
      state_next = state_reg;
      addr_next  = addr_reg;
      tm_next    = tm_reg;
      open_next  = open_reg;
      cve_next   = cve_reg;
      fell_next  = fell_reg;
      wait_next  = wait_reg;
      // transparent while open; a start at a falling edge always captures,
      // even when a foreign-slot start left the latch shut
      if (open_reg || (nb_fall && !start_n_s)) begin
         addr_next = ad_s;
         tm_next   = tm_s;
      end
      // latch stays shut while a cycle is pending, so released host lines
      // cannot replace the address being decoded
      if (nb_fall) begin
         fell_next = 1'b1;
         if (!start_n_s) begin
            open_next = 1'b0;
            cve_next  = 1'b1;
         end else if (!cve_reg) begin
            open_next = 1'b1;
         end
      end
      // acknowledge ends the cycle, so a stray address cannot start another
      if (nb_rise && ack_seen) begin
         cve_next  = 1'b0;
         open_next = 1'b1;
      end
      if (nb_rise) begin
         fell_next = 1'b0;
         unique case (state_reg)
            S0: begin
               wait_next = WAIT_ZERO;
               if (ctrl_bus_request_s) begin
                  state_next = S6;
               end else if (cve_reg && match) begin
                  state_next = S1;
               end
            end
            S1: begin
               wait_next = wait_reg + 8'h01;
               if (berr) begin
                  state_next = S5;
               end else if (dev == DEV_RAM) begin
                  state_next = S2;
               end else if (dev == DEV_ROM) begin
                  state_next = S4;
               end else if (!cack_n_s) begin
                  state_next = S4;
               end else if (wait_reg == WAIT_LIMIT) begin
                  state_next = S5;
               end
            end
            S2: state_next = S3;
            S3: state_next = S4;
            S4: state_next = S0;
            S5: state_next = S0;
            S6: begin
               if (!ctrl_bus_request_s) begin
                  state_next = S0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         state_reg <= S0;
         addr_reg  <= '0;
         tm_reg    <= 2'h0;
         open_reg  <= 1'b1;
         cve_reg   <= 1'b0;
         fell_reg  <= 1'b0;
         wait_reg  <= WAIT_ZERO;
      end else begin
         state_reg <= state_next;
         addr_reg  <= addr_next;
         tm_reg    <= tm_next;
         open_reg  <= open_next;
         cve_reg   <= cve_next;
         fell_reg  <= fell_next;
         wait_reg  <= wait_next;
      end
   end

   // output group, computed from the next state so pins follow it in step
   logic              ack_next;
   logic              err_next;
   logic              dsq_next;
   logic              top_next;
   logic              grant_next;
   logic              ctrl_ad_next;
   logic              haoe_next;
   logic [LOCAL_W-1:0] laddr_next;
   logic              ccs_next;
   logic              rcs_next;
   logic              buf_ram_out_en_next;
   logic              h2l_next;
   logic              h2lu_next;
   logic              l2h_next;
   logic              cwr_next;
   logic              rwu_next;
   logic              rwl_next;
   logic              match_next;

   always_comb begin
      logic gate;
      logic lower_half;
      logic in_s4_low;
      gate         = 1'b0;
      lower_half   = (state_next == S3) | (state_next == S4);
      in_s4_low    = (state_next == S4) & fell_next;
      ack_next     = (state_next == S4) | (state_next == S5);
      err_next     = (state_next == S5);
      // S2 stands apart only because the strobe drops; upper qualifier covers it
      dsq_next     = (state_next == S1) | (state_next == S3) | (state_next == S4);
      top_next     = (state_next == S2) & (dev == DEV_RAM);
      gate         = dsq_next | top_next;
      grant_next   = (state_next == S6);
      ctrl_ad_next = grant_next & ctrl_bus_request_s;
      haoe_next    = ~(grant_next | ((state_next == S0) & ctrl_bus_request_s));
      match_next   = match;
      if (dev == DEV_RAM) begin
         laddr_next = {addr_next[RAM_WORD_HI:WORD_LO], lower_half};
      end else begin
         laddr_next = addr_next[WORD_HI:WORD_LO];
      end
      ccs_next     = dsq_next & (dev == DEV_CTRL);
      rcs_next     = dsq_next & (dev == DEV_ROM) & ~wr;
      buf_ram_out_en_next   = gate & (dev == DEV_RAM) & ~wr;
      h2lu_next    = wr & ((gate & (dev == DEV_RAM) & ~lower_half)
                     | (dsq_next & (dev == DEV_CTRL)));
      h2l_next     = wr & dsq_next & (dev == DEV_RAM) & lower_half;
      l2h_next     = ~wr & gate & (dev != DEV_NONE);
      // strobes drop on the falling edge of the half's last state for hold time
      cwr_next     = wr & (dev == DEV_CTRL)
                     & ((state_next == S1) | ((state_next == S4) & ~in_s4_low));
      rwu_next     = wr & (dev == DEV_RAM)
                     & ((state_next == S1) | ((state_next == S2) & ~fell_next));
      rwl_next     = wr & (dev == DEV_RAM)
                     & ((state_next == S3) | ((state_next == S4) & ~in_s4_low));
      if (state_next == S5) begin
         ccs_next = 1'b0;
         rcs_next = 1'b0;
         l2h_next = 1'b0;
      end
   end

   // output registers; reset leaves the status lines released
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         ACK_N_O                  <= 1'b1;
         ACK_OE_N_O               <= 1'b1;
         TM_O                     <= TM_COMPLETE;
         TM_OE_N_O                <= 1'b1;
         BUS_GRANT_O              <= 1'b0;
         CTRL_ADDR_OUT_EN_O       <= 1'b0;
         HOST_ADDR_LATCH_CLK_O    <= 1'b1;
         HOST_ADDR_OUT_EN_O       <= 1'b1;
         LOCAL_ADDR_O             <= '0;
         SLOT_MATCH_O             <= 1'b0;
         DATA_STROBE_QUAL_O       <= 1'b0;
         UPPER_QUAL_O             <= 1'b0;
         CTRL_CHIP_SEL_O          <= 1'b0;
         ROM_CHIP_SEL_O           <= 1'b0;
         BUF_RAM_OUT_EN_O         <= 1'b0;
         HOST_TO_LOCAL_DATA_EN_O  <= 1'b0;
         HOST_TO_LOCAL_UPPER_EN_O <= 1'b0;
         LOCAL_TO_HOST_DATA_EN_O  <= 1'b0;
         CTRL_WRITE_STROBE_O      <= 1'b0;
         RAM_WRITE_UPPER_O        <= 1'b0;
         RAM_WRITE_LOWER_O        <= 1'b0;
      end else begin
         ACK_N_O                  <= ~ack_next;
         ACK_OE_N_O               <= ~ack_next;
         TM_O                     <= err_next ? TM_BUS_ERROR : TM_COMPLETE;
         TM_OE_N_O                <= ~ack_next;
         BUS_GRANT_O              <= grant_next;
         CTRL_ADDR_OUT_EN_O       <= ctrl_ad_next;
         HOST_ADDR_LATCH_CLK_O    <= open_next;
         HOST_ADDR_OUT_EN_O       <= haoe_next;
         LOCAL_ADDR_O             <= laddr_next;
         SLOT_MATCH_O             <= match_next;
         DATA_STROBE_QUAL_O       <= dsq_next;
         UPPER_QUAL_O             <= top_next;
         CTRL_CHIP_SEL_O          <= ccs_next;
         ROM_CHIP_SEL_O           <= rcs_next;
         BUF_RAM_OUT_EN_O         <= buf_ram_out_en_next;
         HOST_TO_LOCAL_DATA_EN_O  <= h2l_next;
         HOST_TO_LOCAL_UPPER_EN_O <= h2lu_next;
         LOCAL_TO_HOST_DATA_EN_O  <= l2h_next;
         CTRL_WRITE_STROBE_O      <= cwr_next;
         RAM_WRITE_UPPER_O        <= rwu_next;
         RAM_WRITE_LOWER_O        <= rwl_next;
      end
   end

   // the RAM path is fixed at five host clocks, S1 to S4 plus entry; this bounds
   // how long the controller waits behind RAM and ROM accesses, not behind register access

endmodule

// ===== bench/nubus_host_model.sv
// behavioural host bus master for the sequencer's host pins
`timescale 1ns/1ns
module nubus_host_model
   import nubus_seq_pkg::*;
(
   // bench clock
   input  wire logic            clk_i,
   // slave answer
   input  wire logic            ack_n_i,
   input  wire logic [1:0]      tm_i,
   // master drive
   output logic                 nb_clk_o,
   output logic                 start_n_o,
   output logic [AD_W-1:0]      ad_o,
   output logic [1:0]           tm_o
);
   int phase = 0;
   // idle levels before the first transfer
   initial begin
      start_n_o = 1'b1;
      ad_o      = 32'h0;
      tm_o      = 2'h3;
   end
   // host clock at a tenth of the bench clock, mostly high
   always @(posedge clk_i) begin
      phase <= (phase == 9) ? 0 : phase + 1;
   end
   assign nb_clk_o = (phase < 8);
   // one transfer: start for one host clock, then wait for the answer
   task automatic access(input logic [AD_W-1:0] adr, input logic [1:0] tm,
                         output logic [1:0] status, output logic acked);
      int n;
      n = 0;
      acked = 1'b0;
      status = 2'h0;
      do @(posedge clk_i); while (phase != 9);
      start_n_o <= 1'b0;
      ad_o <= adr;
      tm_o <= tm;
      repeat (10) @(posedge clk_i);
      // released lines float up; reads and writes alike leave the inverted address on the address lines
      start_n_o <= 1'b1;
      tm_o <= 2'h3;
      ad_o <= ~adr;
      while (ack_n_i !== 1'b0 && n < 1500) begin
         @(posedge clk_i);
         n++;
      end
      acked = (ack_n_i === 1'b0);
      status = tm_i;
      while (ack_n_i === 1'b0) @(posedge clk_i);
      ad_o <= adr;
   endtask
endmodule

// ===== bench/nubus_sequencer_assertions.sv
// port-level checks on the host bus sequencer
`timescale 1ns/1ns
module nubus_sequencer_assertions
   import nubus_seq_pkg::*;
(
   // watched ports
   input wire logic               CLK_I,
   input wire logic               RST_I,
   input wire logic               CTRL_BUS_REQUEST_I,
   input wire logic               ACK_N_O,
   input wire logic               ACK_OE_N_O,
   input wire logic [1:0]         TM_O,
   input wire logic               TM_OE_N_O,
   input wire logic               BUS_GRANT_O,
   input wire logic               HOST_ADDR_OUT_EN_O,
   input wire logic [LOCAL_W-1:0] LOCAL_ADDR_O,
   input wire logic               DATA_STROBE_QUAL_O,
   input wire logic               UPPER_QUAL_O,
   input wire logic               CTRL_CHIP_SEL_O,
   input wire logic               ROM_CHIP_SEL_O,
   input wire logic               BUF_RAM_OUT_EN_O,
   input wire logic               LOCAL_TO_HOST_DATA_EN_O,
   input wire logic               CTRL_WRITE_STROBE_O
);
   default clocking cb @(posedge CLK_I); endclocking
   // second buffer half: strobe back with low bit set, then acknowledge
   sequence upper_half_done;
      $fell(UPPER_QUAL_O);
   endsequence
   sequence lower_half_acked;
      DATA_STROBE_QUAL_O && LOCAL_ADDR_O[0] ##[5:15] !ACK_N_O;
   endsequence
   AST_RESET: assert property (RST_I |=> ACK_OE_N_O && TM_OE_N_O && !BUS_GRANT_O
      && !DATA_STROBE_QUAL_O && !UPPER_QUAL_O) else $error("not idle after reset");
   AST_RAM_HALVES: assert property (disable iff (RST_I) upper_half_done |-> lower_half_acked)
      else $error("second half wrong");
   AST_UPPER: assert property (disable iff (RST_I) UPPER_QUAL_O
      |-> !DATA_STROBE_QUAL_O && !LOCAL_ADDR_O[0]) else $error("upper qualifier wrong");
   AST_GATE: assert property (disable iff (RST_I) (CTRL_CHIP_SEL_O || ROM_CHIP_SEL_O)
      |-> DATA_STROBE_QUAL_O) else $error("select without strobe");
   AST_RAM_OE: assert property (disable iff (RST_I) BUF_RAM_OUT_EN_O
      |-> DATA_STROBE_QUAL_O || UPPER_QUAL_O) else $error("ram enable ungated");
   AST_ROM: assert property (disable iff (RST_I) ROM_CHIP_SEL_O
      |-> LOCAL_TO_HOST_DATA_EN_O) else $error("rom without outbound buffer");
   AST_STATUS: assert property (disable iff (RST_I) !ACK_OE_N_O
      |-> !ACK_N_O && !TM_OE_N_O && TM_O[1]) else $error("bad status");
   AST_ACK_ONE: assert property (disable iff (RST_I) $fell(ACK_N_O)
      |-> !ACK_N_O [*8] ##[1:4] ACK_N_O) else $error("ack not one host clock");
   AST_ERR: assert property (disable iff (RST_I) !ACK_OE_N_O && TM_O == TM_BUS_ERROR
      |-> !DATA_STROBE_QUAL_O) else $error("strobe in error state");
   AST_GRANT: assert property (disable iff (RST_I) $rose(BUS_GRANT_O)
      |-> CTRL_BUS_REQUEST_I && ACK_OE_N_O && !DATA_STROBE_QUAL_O) else $error("bad grant");
   AST_ADDR_OE: assert property (disable iff (RST_I) BUS_GRANT_O
      |-> !HOST_ADDR_OUT_EN_O) else $error("host address while granted");
   AST_GRANT_END: assert property (disable iff (RST_I) BUS_GRANT_O && !CTRL_BUS_REQUEST_I
      |-> ##[1:25] !BUS_GRANT_O) else $error("grant kept");
   AST_WSTROBE: assert property (disable iff (RST_I) $fell(ACK_N_O) && CTRL_WRITE_STROBE_O
      |-> ##[1:9] !CTRL_WRITE_STROBE_O && !ACK_N_O) else $error("strobe not dropped");
endmodule
bind nubus_sequencer nubus_sequencer_assertions chk (.CLK_I(CLK_I), .RST_I(RST_I),
   .CTRL_BUS_REQUEST_I(CTRL_BUS_REQUEST_I), .ACK_N_O(ACK_N_O), .ACK_OE_N_O(ACK_OE_N_O),
   .TM_O(TM_O), .TM_OE_N_O(TM_OE_N_O), .BUS_GRANT_O(BUS_GRANT_O),
   .HOST_ADDR_OUT_EN_O(HOST_ADDR_OUT_EN_O), .LOCAL_ADDR_O(LOCAL_ADDR_O),
   .DATA_STROBE_QUAL_O(DATA_STROBE_QUAL_O), .UPPER_QUAL_O(UPPER_QUAL_O),
   .CTRL_CHIP_SEL_O(CTRL_CHIP_SEL_O), .ROM_CHIP_SEL_O(ROM_CHIP_SEL_O),
   .BUF_RAM_OUT_EN_O(BUF_RAM_OUT_EN_O), .LOCAL_TO_HOST_DATA_EN_O(LOCAL_TO_HOST_DATA_EN_O),
   .CTRL_WRITE_STROBE_O(CTRL_WRITE_STROBE_O));

// ===== bench/nubus_sequencer_tb_top.sv
// self-checking bench for the host bus sequencer
`timescale 1ns/1ns
module nubus_sequencer_tb_top;
   import nubus_seq_pkg::*;
   logic            clk;
   logic            rst = 1'b1;
   logic            ctrl_bus_request = 1'b0;
   logic            cack_n = 1'b1;
   logic [3:0]      slot_id = 4'hB;
   logic            nb_clk, start_n, ack_n, ack_oe_n, tm_oe_n, grant, latch_clk, dsq, cs;
   logic            haoe, cadoe;
   logic [AD_W-1:0] ad, a;
   logic [1:0]      tm_in, tm_out, tmv, st;
   logic [1:0]      exp_q[$];
   logic            ok;
   int              n_fail = 0;
   int              check_count = 0;
   int              cycles = 0;
   int              seed = 32'hbfda;
   int              ack_cnt = 0;
   int              ack_dly = 3;
   int              n;
   nubus_host_model host (.clk_i(clk), .ack_n_i(ack_n), .tm_i(tm_out), .nb_clk_o(nb_clk),
      .start_n_o(start_n), .ad_o(ad), .tm_o(tm_in));
   nubus_sequencer uut (.CLK_I(clk), .RST_I(rst), .NB_CLK_I(nb_clk), .NB_START_N_I(start_n),
      .NB_AD_I(ad), .NB_TM_I(tm_in), .SLOT_ID_I(slot_id), .ACK_N_O(ack_n),
      .ACK_OE_N_O(ack_oe_n), .TM_O(tm_out), .TM_OE_N_O(tm_oe_n), .CTRL_BUS_REQUEST_I(ctrl_bus_request),
      .CTRL_ACCESS_ACK_N_I(cack_n), .BUS_GRANT_O(grant), .CTRL_ADDR_OUT_EN_O(cadoe),
      .HOST_ADDR_LATCH_CLK_O(latch_clk), .HOST_ADDR_OUT_EN_O(haoe), .LOCAL_ADDR_O(),
      .SLOT_MATCH_O(), .DATA_STROBE_QUAL_O(dsq), .UPPER_QUAL_O(), .CTRL_CHIP_SEL_O(cs),
      .ROM_CHIP_SEL_O(), .BUF_RAM_OUT_EN_O(), .HOST_TO_LOCAL_DATA_EN_O(),
      .HOST_TO_LOCAL_UPPER_EN_O(), .LOCAL_TO_HOST_DATA_EN_O(), .CTRL_WRITE_STROBE_O(),
      .RAM_WRITE_UPPER_O(), .RAM_WRITE_LOWER_O());
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [1:0] seen, input logic [1:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s seen %b expected %b", $time, what, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // reference status: unmapped device or rom write is refused
   function automatic logic [1:0] exp_status(input logic [AD_W-1:0] adr, input logic [1:0] t);
      if (adr[19:18] == 2'h3 || (adr[19:18] == 2'h1 && !t[1]))
         return TM_BUS_ERROR;
      return TM_COMPLETE;
   endfunction
   // controller answers a register access after a random delay
   always @(posedge clk) begin
      ack_cnt <= cs ? ack_cnt + 1 : 0;
      if (cs && ack_cnt >= ack_dly)
         cack_n <= 1'b0;
      else if (!cs)
         cack_n <= 1'b1;
   end
   // hang guard, well above the longest expected run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check({ack_oe_n, tm_oe_n}, 2'h3, "answer released");
      check({grant, dsq}, 2'h0, "grant and strobe idle");
      check({1'b0, latch_clk}, 2'h1, "latch open");
      repeat (4) @(posedge clk);
      // every device code, read and write, random ignored bits
      for (int i = 0; i < 16; i++) begin
         a = $random(seed);
         a[31:24] = {SLOT_SPACE, slot_id};
         a[19:18] = i[1:0];
         tmv = {i[2], a[0]};
         ack_dly = $random(seed) & 15;
         exp_q.push_back(exp_status(a, tmv));
         host.access(a, tmv, st, ok);
         check({1'b0, ok}, 2'h1, "access acknowledged");
         check(st, exp_q.pop_front(), "status code");
      end
      a[31:24] = {SLOT_SPACE, slot_id + 4'h1};
      host.access(a, 2'h3, st, ok);
      check({1'b0, ok}, 2'h0, "foreign slot ignored");
      // controller request raised with a host start: controller first
      a[31:24] = {SLOT_SPACE, slot_id};
      a[19:18] = 2'h2;
      fork
         host.access(a, 2'h3, st, ok);
         begin
            @(posedge clk iff !start_n);
            ctrl_bus_request <= 1'b1;
            n = 0;
            while (grant !== 1'b1 && n < 40) begin
               @(posedge clk);
               n++;
            end
            check({1'b0, grant}, 2'h1, "controller served first");
            check({haoe, cadoe}, 2'h1, "address path handed over");
            repeat (150) begin
               @(posedge clk);
               check({ack_n, dsq}, 2'h2, "host held off");
            end
            ctrl_bus_request <= 1'b0;
         end
      join
      check({1'b0, ok}, 2'h1, "held access served");
      check(st, TM_COMPLETE, "held access status");
      check({haoe, cadoe}, 2'h2, "host address restored");
      tally_and_finish();
   end
endmodule
